// file: verilog/pmc_pkg.sv
// constants, field layouts and carrier types of the per-axis motion block
// assumes a 250 MHz system clock and an APB master with 32-bit data
// Overview of operation
// - two pulse lines or pulse plus direction
// - constant, linear or S-curve speed profiles
// - decel point automatic or manually set
// - with manual decel point, hold speed instead of triangular profile
// - pulse count and speed change while driving
// - feedback quadrature or up/down pulses
// - quadrature counts at x1, x2 or x4
// - signed logical and real counters, read/write
// - compare with upper and lower registers
// - accel, decel and compare status outputs
// - four-step home search, enables and directions
// - sync trigger from own-axis events
// - sync action executes on other axis
// - individually enabled interrupt sources
// - four stop inputs, enable and level
// - alarm and settled inputs enable, level
// - four outputs general or drive status
// - limits with level and stop mode
// - emergency halt stops pulses immediately
package pmc_pkg;
	// *********************************************
	// timing
	// *********************************************
	localparam int          CLK_MHZ   = 250;
	localparam int          FILT_NS   = 500;
	localparam logic [7:0]  FILT_CYC  = 8'((FILT_NS * CLK_MHZ + 999) / 1000);
	localparam int          PULSE_NS  = 100;
	localparam logic [7:0]  PULSE_CYC = 8'((PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam int          PROF_US   = 1;
	localparam logic [15:0] PROF_CYC  = 16'(PROF_US * CLK_MHZ);
	localparam longint      MAX_PPS   = 4000000;
	localparam logic [31:0] MAX_RATE  = 32'((MAX_PPS << 32) / (longint'(CLK_MHZ) * 1000000));
	// *********************************************
	// register offsets
	// *********************************************
	localparam logic [7:0] A_CMD = 8'h00, A_MODE = 8'h04, A_PULSES = 8'h08, A_SPEED = 8'h0C;
	localparam logic [7:0] A_INIT = 8'h10, A_ACCEL = 8'h14, A_DECEL = 8'h18, A_JERK = 8'h1C;
	localparam logic [7:0] A_DPOINT = 8'h20, A_LPOS = 8'h24, A_RPOS = 8'h28, A_UPPER = 8'h2C;
	localparam logic [7:0] A_LOWER = 8'h30, A_STATUS = 8'h34, A_INT_EN = 8'h38, A_INT_ST = 8'h3C;
	localparam logic [7:0] A_HOME = 8'h40, A_HLOW = 8'h44, A_SYNC = 8'h48, A_SVAL = 8'h4C;
	localparam logic [7:0] A_LATCH_L = 8'h50, A_LATCH_R = 8'h54, A_GENOUT = 8'h58;
	localparam logic [31:0] SPEED_RST = 32'h0000_1000, INIT_RST = 32'h0000_0100;
	localparam logic [31:0] ACCEL_RST = 32'h0000_0010;
	// command bits
	localparam int C_FIX_P = 0, C_FIX_M = 1, C_CON_P = 2, C_CON_M = 3, C_DSTOP = 4;
	localparam int C_ISTOP = 5, C_HOME = 6, C_ACTIVATE = 7, C_LATCH = 8;
	// interrupt bits
	localparam int I_PULSE = 0, I_CST = 1, I_CEND = 2, I_DEND = 3, I_UP_SET = 4;
	localparam int I_UP_CLR = 5, I_LO_SET = 6, I_LO_CLR = 7, I_HOME = 8, I_SYNC = 9, NINT = 10;
	localparam logic [1:0] PR_CONST = 2'h0, PR_LINEAR = 2'h1, PR_SCURVE = 2'h2;
	typedef enum logic [3:0] {
		ACT_NONE = 4'h0, ACT_FIX_P = 4'h1, ACT_FIX_M = 4'h2, ACT_CON_P = 4'h3,
		ACT_CON_M = 4'h4, ACT_DSTOP = 4'h5, ACT_ISTOP = 4'h6, ACT_SAVE = 4'h7,
		ACT_LOAD = 4'h8, ACT_SET_PULSES = 4'h9, ACT_SET_SPEED = 4'hA, ACT_IRQ = 4'hB
	} pmc_act_t;
	typedef enum logic [3:0] {
		TR_UP_SET = 4'h0, TR_UP_CLR = 4'h1, TR_LO_SET = 4'h2, TR_LO_CLR = 4'h3,
		TR_START = 4'h4, TR_END = 4'h5, TR_IN3_RISE = 4'h6, TR_IN3_FALL = 4'h7,
		TR_LATCH = 4'h8, TR_ACTIVATE = 4'h9
	} pmc_trig_t;
	// *********************************************
	// carrier types
	// *********************************************
	typedef struct packed {
		logic       ext_plus_drive_in;
		logic       ext_minus_drive_in;
		logic [3:0] stop_in;
		logic       limit_plus_in;
		logic       limit_minus_in;
		logic       servo_alarm_in;
		logic       servo_settled_in;
		logic       emergency_halt_in;
		logic       enc_a_in;
		logic       enc_b_in;
	} pmc_field_t;
	typedef struct packed {
		logic     req;
		pmc_act_t action;
	} pmc_sync_t;
	typedef struct packed {
		logic       reserved;
		logic       ext_cont;
		logic       soft_limit_en;
		logic [3:0] out_status_sel;
		logic [3:0] stop_instant;
		logic [3:0] stop_level;
		logic [3:0] stop_en;
		logic       settled_level;
		logic       settled_en;
		logic       alarm_level;
		logic       alarm_en;
		logic       limit_level;
		logic       limit_instant;
		logic [1:0] quad_mult;
		logic       fb_updown;
		logic       manual_decel;
		logic [1:0] profile;
		logic       pulse_dir_fmt;
	} pmc_mode_t;
	typedef struct packed {
		logic [21:0] reserved;
		logic        cmp_real;
		logic        enable;
		pmc_act_t    action;
		pmc_trig_t   trigger;
	} pmc_synccfg_t;
endpackage

// file: verilog/pmc_axis.sv
// one axis of the pulse-train motion controller with its APB register file
// assumes field inputs already synchronous to CLK_I; emergency shared by all axes
`timescale 1ns/100ps
module pmc_axis (
	input  wire logic                CLK_I,
	input  wire logic                RST_N_I,
	input  wire logic                PSEL_I,
	input  wire logic                PENABLE_I,
	input  wire logic                PWRITE_I,
	input  wire logic [7:0]          PADDR_I,
	input  wire logic [31:0]         PWDATA_I,
	output logic      [31:0]         PRDATA_O,
	output logic                     PREADY_O,
	output logic                     PSLVERR_O,
	input  wire pmc_pkg::pmc_field_t FIELD_I,
	input  wire pmc_pkg::pmc_sync_t  SYNC_I,
	output pmc_pkg::pmc_sync_t       SYNC_O,
	output logic                     PULSE_A_O,
	output logic                     PULSE_B_O,
	output logic      [3:0]          OUT_O,
	output logic                     IRQ_O
);
	import pmc_pkg::*;
	localparam int NF = 11;
	typedef enum logic [4:0] {
		D_IDLE = 5'b00001, D_ACC = 5'b00010, D_CST = 5'b00100,
		D_DEC = 5'b01000, D_SET = 5'b10000
	} pmc_drv_t;
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001, H_S1 = 5'b00010, H_S2 = 5'b00100,
		H_S3 = 5'b01000, H_S4 = 5'b10000
	} pmc_home_t;
	pmc_mode_t    mode;
	pmc_synccfg_t scfg;
	pmc_drv_t     st, st_q;
	pmc_home_t    hst;
	logic [31:0]  pulses, speed, init_sp, accel, decel, jerk, dpoint, upper, lower;
	logic [31:0]  lpos, rpos, sval, latch_l, latch_r, hlow;
	logic [7:0]   hcfg;
	logic [3:0]   genout;
	logic [NINT-1:0] int_en, int_st, ev;
	logic [31:0]  done, ramp, cur, acc_now, ph, remaining, tgt, tgt_raw, ini, pos;
	logic [32:0]  ph_sum, up_sum;
	logic         dir, cont, tick, carry, busy, busy_q, h_go, home_done;
	logic [7:0]   pw;
	logic [15:0]  pdiv;
	logic         prof_tick;
	logic [NF-1:0] fin, ff, ff_q;
	logic [1:0]   ab_q;
	logic [2:0]   h_from;
	logic         idx_q, above, below, above_q, below_q;
	logic         wr, cmd_wr, mapped;
	logic         start_req, start_dir, start_cont, stop_dec, stop_inst;
	logic         fb_ev, fb_up, sync_fire, s_act, at_dpoint;
	logic [3:0]   stop_act, stat4;
	logic         lim_p, lim_m, alarm_act, settled_act, emerg;
	// *********************************************
	// input filters
	// *********************************************
	assign fin = {FIELD_I.ext_plus_drive_in, FIELD_I.ext_minus_drive_in, FIELD_I.stop_in,
		FIELD_I.limit_plus_in, FIELD_I.limit_minus_in, FIELD_I.servo_alarm_in,
		FIELD_I.servo_settled_in, FIELD_I.emergency_halt_in};
	genvar g;
	generate
		for (g = 0; g < NF; g++)
		begin : g_filt
			logic [7:0] cnt;
			logic       q;
			always_ff @(posedge CLK_I)
			begin
				if (!RST_N_I)
				begin
					cnt <= 8'h00;
					q <= 1'b0;
				end
				else if (fin[g] == q)
					cnt <= 8'h00;
				else if (cnt == FILT_CYC - 8'h01)
				begin
					q <= fin[g];
					cnt <= 8'h00;
				end
				else
					cnt <= cnt + 8'h01;
			end
			assign ff[g] = q;
		end
	endgenerate
	// ff bits: 10 ext+, 9 ext-, 8..5 stop[3:0], 4 lim+, 3 lim-, 2 alarm, 1 settled, 0 emerg
	assign lim_p = ff[4] == mode.limit_level;
	assign lim_m = ff[3] == mode.limit_level;
	assign alarm_act = mode.alarm_en && (ff[2] == mode.alarm_level);
	assign settled_act = !mode.settled_en || (ff[1] == mode.settled_level);
	assign emerg = ff[0];
	generate
		for (g = 0; g < 4; g++)
		begin : g_stop
			assign stop_act[g] = mode.stop_en[g] && (ff[5 + g] == mode.stop_level[g]);
		end
	endgenerate
	// *********************************************
	// APB slave
	// *********************************************
	assign wr = PSEL_I && PENABLE_I && PWRITE_I;
	assign cmd_wr = wr && (PADDR_I == A_CMD);
	assign mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= A_GENOUT);
	assign PREADY_O = 1'b1;
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			PRDATA_O <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end
		else if (PSEL_I && !PENABLE_I)
		begin
			PSLVERR_O <= !mapped;
			unique case (PADDR_I)
				A_MODE:    PRDATA_O <= mode;
				A_PULSES:  PRDATA_O <= pulses;
				A_SPEED:   PRDATA_O <= speed;
				A_INIT:    PRDATA_O <= init_sp;
				A_ACCEL:   PRDATA_O <= accel;
				A_DECEL:   PRDATA_O <= decel;
				A_JERK:    PRDATA_O <= jerk;
				A_DPOINT:  PRDATA_O <= dpoint;
				A_LPOS:    PRDATA_O <= lpos;
				A_RPOS:    PRDATA_O <= rpos;
				A_UPPER:   PRDATA_O <= upper;
				A_LOWER:   PRDATA_O <= lower;
				A_STATUS:  PRDATA_O <= {17'h0, hst != H_IDLE, ff[1], ff[2], ff[3], ff[4],
					ff[8:5], below, above, st == D_CST, st == D_DEC, st == D_ACC, busy};
				A_INT_EN:  PRDATA_O <= {22'h0, int_en};
				A_INT_ST:  PRDATA_O <= {22'h0, int_st};
				A_HOME:    PRDATA_O <= {24'h0, hcfg};
				A_HLOW:    PRDATA_O <= hlow;
				A_SYNC:    PRDATA_O <= scfg;
				A_SVAL:    PRDATA_O <= sval;
				A_LATCH_L: PRDATA_O <= latch_l;
				A_LATCH_R: PRDATA_O <= latch_r;
				A_GENOUT:  PRDATA_O <= {28'h0, genout};
				default:   PRDATA_O <= 32'h0000_0000;
			endcase
		end
	end
	assign s_act = SYNC_I.req;
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			mode <= '0;
			scfg <= '0;
			pulses <= 32'h0000_0000;
			speed <= SPEED_RST;
			init_sp <= INIT_RST;
			accel <= ACCEL_RST;
			decel <= ACCEL_RST;
			jerk <= ACCEL_RST;
			dpoint <= 32'h0000_0000;
			upper <= 32'h7FFF_FFFF;
			lower <= 32'h8000_0000;
			int_en <= '0;
			hcfg <= 8'h00;
			hlow <= INIT_RST;
			sval <= 32'h0000_0000;
			genout <= 4'h0;
		end
		else
		begin
			if (wr)
			begin
				unique case (PADDR_I)
					A_MODE:   mode <= PWDATA_I;
					A_PULSES: pulses <= PWDATA_I;
					A_SPEED:  speed <= PWDATA_I;
					A_INIT:   init_sp <= PWDATA_I;
					A_ACCEL:  accel <= PWDATA_I;
					A_DECEL:  decel <= PWDATA_I;
					A_JERK:   jerk <= PWDATA_I;
					A_DPOINT: dpoint <= PWDATA_I;
					A_UPPER:  upper <= PWDATA_I;
					A_LOWER:  lower <= PWDATA_I;
					A_INT_EN: int_en <= PWDATA_I[NINT-1:0];
					A_HOME:   hcfg <= PWDATA_I[7:0];
					A_HLOW:   hlow <= PWDATA_I;
					A_SYNC:   scfg <= PWDATA_I;
					A_SVAL:   sval <= PWDATA_I;
					A_GENOUT: genout <= PWDATA_I[3:0];
					default:  ;
				endcase
			end
			if (s_act && SYNC_I.action == ACT_SET_PULSES)
				pulses <= sval;
			if (s_act && SYNC_I.action == ACT_SET_SPEED)
				speed <= sval;
		end
	end
	// *********************************************
	// start and stop requests
	// *********************************************
	always_comb
	begin
		start_req = 1'b0;
		start_dir = 1'b0;
		start_cont = 1'b0;
		if (hst != H_IDLE && !h_go && st == D_IDLE)
		begin
			start_req = 1'b1;
			start_dir = (hst == H_S1) ? hcfg[4] : (hst == H_S2) ? hcfg[5] :
				(hst == H_S3) ? hcfg[6] : hcfg[7];
			start_cont = hst != H_S4;
		end
		else if (cmd_wr && |PWDATA_I[C_CON_M:C_FIX_P])
		begin
			start_req = 1'b1;
			start_dir = PWDATA_I[C_FIX_M] || PWDATA_I[C_CON_M];
			start_cont = PWDATA_I[C_CON_P] || PWDATA_I[C_CON_M];
		end
		else if (s_act && SYNC_I.action inside {ACT_FIX_P, ACT_FIX_M, ACT_CON_P, ACT_CON_M})
		begin
			start_req = 1'b1;
			start_dir = SYNC_I.action inside {ACT_FIX_M, ACT_CON_M};
			start_cont = SYNC_I.action inside {ACT_CON_P, ACT_CON_M};
		end
		else if ((ff[10] && !ff_q[10]) || (ff[9] && !ff_q[9]))
		begin
			start_req = 1'b1;
			start_dir = ff[9];
			start_cont = mode.ext_cont;
		end
	end
	always_comb
	begin
		stop_inst = emerg || alarm_act;
		stop_inst = stop_inst || (cmd_wr && PWDATA_I[C_ISTOP]);
		stop_inst = stop_inst || (s_act && SYNC_I.action == ACT_ISTOP);
		stop_inst = stop_inst || |(stop_act & mode.stop_instant);
		stop_inst = stop_inst || (mode.limit_instant && (dir ? lim_m : lim_p));
		stop_dec = cmd_wr && PWDATA_I[C_DSTOP];
		stop_dec = stop_dec || (s_act && SYNC_I.action == ACT_DSTOP);
		stop_dec = stop_dec || |(stop_act & ~mode.stop_instant);
		stop_dec = stop_dec || (!mode.limit_instant && (dir ? lim_m : lim_p));
		stop_dec = stop_dec || (mode.soft_limit_en && (dir ? below : above));
		stop_dec = stop_dec || (mode.ext_cont && ((!ff[10] && ff_q[10]) || (!ff[9] && ff_q[9])));
		stop_dec = stop_dec || (h_go && hst == H_S1 && stop_act[1]);
		stop_inst = stop_inst || (h_go && hst == H_S2 && stop_act[2]);
		stop_inst = stop_inst || (h_go && hst == H_S3 && FIELD_I.stop_in[0] && !idx_q);
	end
	// *********************************************
	// drive profile and pulse generation
	// *********************************************
	assign busy = st != D_IDLE;
	assign remaining = (done >= pulses) ? 32'h0000_0000 : pulses - done;
	assign tgt_raw = (hst == H_S2 || hst == H_S3) ? hlow : speed;
	assign tgt = (tgt_raw > MAX_RATE) ? MAX_RATE : tgt_raw;
	assign ini = (init_sp > tgt) ? tgt : init_sp;
	assign at_dpoint = !cont && mode.profile != PR_CONST &&
		(mode.manual_decel ? remaining <= dpoint : remaining <= ramp);
	assign ph_sum = {1'b0, ph} + {1'b0, cur};
	assign up_sum = {1'b0, cur} + {1'b0, acc_now};
	assign carry = ph_sum[32] && (cont || remaining != 32'h0000_0000);
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			pdiv <= 16'h0000;
		else if (pdiv == PROF_CYC - 16'h0001)
			pdiv <= 16'h0000;
		else
			pdiv <= pdiv + 16'h0001;
	end
	assign prof_tick = pdiv == 16'h0000;
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			st <= D_IDLE;
			dir <= 1'b0;
			cont <= 1'b0;
			done <= 32'h0000_0000;
			ramp <= 32'h0000_0000;
			cur <= 32'h0000_0000;
			acc_now <= 32'h0000_0000;
			ph <= 32'h0000_0000;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (st inside {D_ACC, D_CST, D_DEC}) && carry;
			if (st inside {D_ACC, D_CST, D_DEC})
				ph <= ph_sum[31:0];
			if (tick)
				done <= done + 32'h0000_0001;
			if (tick && st == D_ACC)
				ramp <= ramp + 32'h0000_0001;
			if (busy && st != D_SET && (stop_inst || (!cont && remaining == 32'h0000_0000)))
				st <= mode.settled_en ? D_SET : D_IDLE;
			else
			begin
				unique case (st)
					D_IDLE:
					begin
						if (start_req && !stop_inst)
						begin
							st <= (mode.profile == PR_CONST) ? D_CST : D_ACC;
							cur <= (mode.profile == PR_CONST) ? tgt : ini;
							acc_now <= (mode.profile == PR_SCURVE) ? 32'h0000_0000 : accel;
							dir <= start_dir;
							cont <= start_cont;
							done <= 32'h0000_0000;
							ramp <= 32'h0000_0000;
							ph <= 32'h0000_0000;
						end
					end
					D_ACC:
					begin
						if (stop_dec || at_dpoint)
						begin
							st <= D_DEC;
							acc_now <= (mode.profile == PR_SCURVE) ? 32'h0000_0000 : decel;
						end
						else if (!cont && done >= remaining)
							st <= D_CST;
						else if (prof_tick)
						begin
							if (mode.profile == PR_SCURVE)
								acc_now <= (acc_now + jerk > accel) ? accel : acc_now + jerk;
							if (up_sum >= {1'b0, tgt})
							begin
								cur <= tgt;
								st <= D_CST;
							end
							else
								cur <= up_sum[31:0];
						end
					end
					D_CST:
					begin
						if (stop_dec || at_dpoint)
						begin
							st <= (mode.profile == PR_CONST && cont) ? D_IDLE : D_DEC;
							acc_now <= (mode.profile == PR_SCURVE) ? 32'h0000_0000 : decel;
						end
						else if (mode.profile == PR_CONST)
							cur <= tgt;
						else if (prof_tick && tgt > cur)
							cur <= (tgt - cur > accel) ? cur + accel : tgt;
						else if (prof_tick && tgt < cur)
							cur <= (cur - tgt > decel) ? cur - decel : tgt;
					end
					D_DEC:
					begin
						if (cont && cur <= ini)
							st <= mode.settled_en ? D_SET : D_IDLE;
						else if (prof_tick)
						begin
							if (mode.profile == PR_SCURVE)
								acc_now <= (acc_now + jerk > decel) ? decel : acc_now + jerk;
							cur <= (cur < ini + acc_now) ? ini : cur - acc_now;
						end
					end
					D_SET:
					begin
						if (settled_act)
							st <= D_IDLE;
					end
					default: st <= D_IDLE;
				endcase
			end
		end
	end
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			pw <= 8'h00;
			PULSE_A_O <= 1'b0;
			PULSE_B_O <= 1'b0;
		end
		else
		begin
			pw <= tick ? PULSE_CYC : (pw != 8'h00) ? pw - 8'h01 : 8'h00;
			PULSE_A_O <= (pw != 8'h00) && (mode.pulse_dir_fmt || !dir);
			PULSE_B_O <= mode.pulse_dir_fmt ? dir : (pw != 8'h00) && dir;
		end
	end
	// *********************************************
	// position counters and compare
	// *********************************************
	always_comb
	begin
		fb_ev = 1'b0;
		fb_up = 1'b0;
		if (mode.fb_updown)
		begin
			fb_ev = (FIELD_I.enc_a_in && !ab_q[1]) ^ (FIELD_I.enc_b_in && !ab_q[0]);
			fb_up = FIELD_I.enc_a_in && !ab_q[1];
		end
		else
		begin
			fb_up = FIELD_I.enc_a_in ^ ab_q[0];
			unique case (mode.quad_mult)
				2'h0:    fb_ev = FIELD_I.enc_a_in && !ab_q[1];
				2'h1:    fb_ev = FIELD_I.enc_a_in ^ ab_q[1];
				default: fb_ev = (FIELD_I.enc_a_in ^ ab_q[1]) || (FIELD_I.enc_b_in ^ ab_q[0]);
			endcase
		end
	end
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			lpos <= 32'h0000_0000;
			rpos <= 32'h0000_0000;
			latch_l <= 32'h0000_0000;
			latch_r <= 32'h0000_0000;
		end
		else
		begin
			if (wr && PADDR_I == A_LPOS)
				lpos <= PWDATA_I;
			else if (s_act && SYNC_I.action == ACT_LOAD)
				lpos <= sval;
			else if (tick)
				lpos <= dir ? lpos - 32'h0000_0001 : lpos + 32'h0000_0001;
			if (wr && PADDR_I == A_RPOS)
				rpos <= PWDATA_I;
			else if (fb_ev)
				rpos <= fb_up ? rpos + 32'h0000_0001 : rpos - 32'h0000_0001;
			if ((s_act && SYNC_I.action == ACT_SAVE) || (cmd_wr && PWDATA_I[C_LATCH]))
			begin
				latch_l <= lpos;
				latch_r <= rpos;
			end
		end
	end
	assign pos = scfg.cmp_real ? rpos : lpos;
	assign above = $signed(pos) >= $signed(upper);
	assign below = $signed(pos) < $signed(lower);
	// *********************************************
	// home search
	// *********************************************
	function automatic pmc_home_t next_step(input logic [2:0] from, input logic [3:0] en);
		pmc_home_t r;
		r = H_IDLE;
		for (int k = 3; k >= 0; k--)
		begin
			if (en[k] && k >= int'(from))
				r = pmc_home_t'(5'(2) << k);
		end
		return r;
	endfunction
	// number of the active step, 1 to 4; the search resumes above it
	assign h_from = {hst[4], hst[2] || hst[3], hst[1] || hst[3]};
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			hst <= H_IDLE;
			h_go <= 1'b0;
			home_done <= 1'b0;
		end
		else
		begin
			home_done <= 1'b0;
			if (hst == H_IDLE)
			begin
				if (cmd_wr && PWDATA_I[C_HOME] && !busy)
					hst <= next_step(3'h0, hcfg[3:0]);
			end
			else if (emerg || alarm_act)
			begin
				hst <= H_IDLE;
				h_go <= 1'b0;
			end
			else if (start_req && !h_go)
				h_go <= 1'b1;
			else if (h_go && !busy)
			begin
				h_go <= 1'b0;
				hst <= next_step(h_from, hcfg[3:0]);
				// done once no enabled step follows the one just finished
				home_done <= next_step(h_from, hcfg[3:0]) == H_IDLE;
			end
		end
	end
	// *********************************************
	// synchronous action, events, interrupt, outputs
	// *********************************************
	always_comb
	begin
		unique case (scfg.trigger)
			TR_UP_SET:   sync_fire = above && !above_q;
			TR_UP_CLR:   sync_fire = !above && above_q;
			TR_LO_SET:   sync_fire = below && !below_q;
			TR_LO_CLR:   sync_fire = !below && below_q;
			TR_START:    sync_fire = busy && !busy_q;
			TR_END:      sync_fire = !busy && busy_q;
			TR_IN3_RISE: sync_fire = ff[8] && !ff_q[8];
			TR_IN3_FALL: sync_fire = !ff[8] && ff_q[8];
			TR_LATCH:    sync_fire = cmd_wr && PWDATA_I[C_LATCH];
			TR_ACTIVATE: sync_fire = cmd_wr && PWDATA_I[C_ACTIVATE];
			default:     sync_fire = 1'b0;
		endcase
	end
	assign ev[I_PULSE] = tick;
	assign ev[I_CST] = st == D_CST && st_q != D_CST;
	assign ev[I_CEND] = st_q == D_CST && st != D_CST;
	assign ev[I_DEND] = !busy && busy_q;
	assign ev[I_UP_SET] = above && !above_q;
	assign ev[I_UP_CLR] = !above && above_q;
	assign ev[I_LO_SET] = !below && below_q;
	assign ev[I_LO_CLR] = below && !below_q;
	assign ev[I_HOME] = home_done;
	assign ev[I_SYNC] = (scfg.enable && sync_fire) || (s_act && SYNC_I.action == ACT_IRQ);
	assign stat4 = {below, above, st == D_DEC, st == D_ACC};
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			st_q <= D_IDLE;
			busy_q <= 1'b0;
			above_q <= 1'b0;
			below_q <= 1'b0;
			ff_q <= '0;
			ab_q <= 2'h0;
			idx_q <= 1'b0;
			int_st <= '0;
			IRQ_O <= 1'b0;
			SYNC_O <= '0;
			OUT_O <= 4'h0;
		end
		else
		begin
			st_q <= st;
			busy_q <= busy;
			above_q <= above;
			below_q <= below;
			ff_q <= ff;
			ab_q <= {FIELD_I.enc_a_in, FIELD_I.enc_b_in};
			idx_q <= FIELD_I.stop_in[0];
			// a new event wins over a same-cycle write-one clear
			int_st <= (int_st & ~((wr && PADDR_I == A_INT_ST) ? PWDATA_I[NINT-1:0] : '0)) | ev;
			IRQ_O <= |(int_st & int_en);
			SYNC_O.req <= scfg.enable && sync_fire;
			SYNC_O.action <= scfg.action;
			for (int i = 0; i < 4; i++)
				OUT_O[i] <= mode.out_status_sel[i] ? stat4[i] : genout[i];
		end
	end
endmodule

// file: bench/pmc_axis_monitor.sv
// port checker of one motion axis
// bound to pmc_axis from the bench top file; sees only its ports
`timescale 1ns/100ps
module pmc_axis_monitor (
	input wire logic                CLK_I,
	input wire logic                RST_N_I,
	input wire logic                PSEL_I,
	input wire logic                PENABLE_I,
	input wire logic                PWRITE_I,
	input wire logic [7:0]          PADDR_I,
	input wire logic [31:0]         PRDATA_O,
	input wire logic                PREADY_O,
	input wire logic                PSLVERR_O,
	input wire pmc_pkg::pmc_field_t FIELD_I,
	input wire pmc_pkg::pmc_sync_t  SYNC_O,
	input wire logic                PULSE_A_O,
	input wire logic [3:0]          OUT_O,
	input wire logic                IRQ_O
);
	import pmc_pkg::*;
	logic [7:0] hi_cnt;
	logic [7:0] emg_cnt;
	wire        setup = PSEL_I && !PENABLE_I;
	wire        bad   = PADDR_I > 8'h58 || PADDR_I[1:0] != 2'h0;
	// cycles the pulse line has been high
	always_ff @(posedge CLK_I) hi_cnt <= (PULSE_A_O && RST_N_I) ? hi_cnt + 8'h01 : 8'h00;
	// age of the raw emergency level, saturating
	always_ff @(posedge CLK_I) emg_cnt <= FIELD_I.emergency_halt_in ?
		emg_cnt + {7'h00, emg_cnt != 8'hFF} : 8'h00;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	AST_READY: assert property (PREADY_O) else $error("pready low");
	AST_ERR_BAD: assert property (setup && bad |=> PSLVERR_O) else $error("no error");
	AST_ERR_OK: assert property (setup && !bad |=> !PSLVERR_O) else $error("false error");
	AST_RD_ZERO: assert property (setup && bad && !PWRITE_I |=> PRDATA_O == 32'h0)
		else $error("unmapped read not zero");
	AST_QUIET: assert property (disable iff (1'b0) !RST_N_I |=> !PULSE_A_O && OUT_O == 4'h0
		&& !IRQ_O && !SYNC_O.req) else $error("outputs active in reset");
	AST_WIDTH: assert property ($fell(PULSE_A_O) && emg_cnt == 8'h00 |-> hi_cnt == PULSE_CYC)
		else $error("pulse width wrong");
	AST_HALT: assert property (emg_cnt >= 8'hA0 |-> !PULSE_A_O) else $error("pulse in halt");
	AST_SYNC_ONE: assert property (SYNC_O.req |=> !SYNC_O.req) else $error("sync too long");
endmodule

// file: bench/pmc_field_model.sv
// motor drive and encoder model: one quadrature edge per drive pulse
// assumes the two-line pulse format; other field lines come from the bench
`timescale 1ns/100ps
module pmc_field_model (
	input  wire logic                clk_i,
	input  wire logic                pulse_a_i,
	input  wire logic                pulse_b_i,
	input  wire pmc_pkg::pmc_field_t ctl_i,
	output pmc_pkg::pmc_field_t      field_o
);
	import pmc_pkg::*;
	logic [1:0] phase = 2'h0;
	logic       a_q = 1'b0, b_q = 1'b0;
	always @(posedge clk_i)
	begin
		a_q <= pulse_a_i;
		b_q <= pulse_b_i;
		if (pulse_a_i && !a_q)
			phase <= phase + 2'h1;
		else if (pulse_b_i && !b_q)
			phase <= phase - 2'h1;
	end
	// a leads b on plus moves; drive requests held as levels by the bench
	assign field_o = {ctl_i[12:2], phase[1] ^ phase[0], phase[1]};
endmodule

// file: bench/pmc_axis_tb.sv
// self-checking bench of one motion axis
// APB master and field levels here; encoder lines come from pmc_field_model
`timescale 1ns/100ps
module pmc_axis_tb;
	import pmc_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, pa, pb, irq;
	logic [3:0]  outs;
	pmc_field_t  ctl = '0, field;
	pmc_sync_t   sync_in = '0, sync_out;
	int          fail_count = 0, samples_checked = 0, cyc = 0, na = 0, nb = 0, ns = 0;
	pmc_axis dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .FIELD_I(field), .SYNC_I(sync_in),
		.SYNC_O(sync_out), .PULSE_A_O(pa), .PULSE_B_O(pb), .OUT_O(outs), .IRQ_O(irq));
	pmc_field_model fm (.clk_i(clk), .pulse_a_i(pa), .pulse_b_i(pb), .ctl_i(ctl),
		.field_o(field));
	initial forever #2 clk = ~clk;
	always @(posedge clk) if (++cyc == 20000) report_and_stop(1'b1);
	always @(posedge pa) na++;
	always @(posedge pb) nb++;
	always @(posedge clk) ns += int'(sync_out.req === 1'b1);
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(rd, e);
	endtask
	task automatic t_regs;
		rdchk(A_SPEED, SPEED_RST);
		rdchk(A_UPPER, 32'h7FFF_FFFF);
		rdchk(A_LOWER, 32'h8000_0000);
		rdchk(8'h5C, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_drive;
		apb(1'b1, A_SPEED, MAX_RATE);
		for (int m = 0; m < 3; m++)
		begin
			apb(1'b1, A_MODE, (32'(m) << 5) | 32'h100);
			apb(1'b1, A_LPOS, 32'hFFFF_FFFE);
			apb(1'b1, A_RPOS, 32'h0);
			apb(1'b1, A_PULSES, 32'h4);
			na = 0;
			nb = 0;
			apb(1'b1, A_CMD, 32'h1);
			for (int i = 0; i < 400 && (i == 0 || rd[0] === 1'b1); i++) apb(1'b0, A_STATUS, 32'h0);
			rdchk(A_LPOS, 32'h2);
			rdchk(A_RPOS, 32'h1 << m);
			cmp(32'(na * 16 + nb), 32'h40);
		end
		$display("test drive done");
	endtask
	task automatic t_out;
		apb(1'b1, A_MODE, 32'h0);
		apb(1'b1, A_GENOUT, 32'hB);
		repeat (2) @(posedge clk);
		cmp({28'h0, outs}, 32'hB);
		apb(1'b1, A_MODE, 32'h0800_0000);
		apb(1'b1, A_UPPER, 32'h8000_0000);
		repeat (3) @(posedge clk);
		cmp({28'h0, outs}, 32'hF);
		$display("test outputs done");
	endtask
	task automatic t_emg;
		apb(1'b1, A_MODE, 32'h100);
		apb(1'b1, A_CMD, 32'h4);
		repeat (40) @(posedge clk);
		ctl.emergency_halt_in <= 1'b1;
		repeat (200) @(posedge clk);
		na = 0;
		repeat (100) @(posedge clk);
		cmp(32'(na), 32'h0);
		ctl <= '0;
		repeat (150) @(posedge clk);
		apb(1'b0, A_STATUS, 32'h0);
		cmp({31'h0, rd[0]}, 32'h0);
		$display("test halt done");
	endtask
	task automatic t_sync;
		apb(1'b1, A_SYNC, 32'h1B9);
		ns = 0;
		apb(1'b1, A_CMD, 32'h80);
		repeat (3) @(posedge clk);
		cmp(32'(ns), 32'h1);
		apb(1'b1, A_INT_ST, 32'h3FF);
		@(posedge clk);
		sync_in <= '{1'b1, ACT_IRQ};
		@(posedge clk);
		sync_in <= '0;
		repeat (3) @(posedge clk);
		cmp({31'h0, irq}, 32'h0);
		apb(1'b1, A_INT_EN, 32'h200);
		repeat (3) @(posedge clk);
		cmp({31'h0, irq}, 32'h1);
		apb(1'b1, A_INT_ST, 32'h200);
		repeat (3) @(posedge clk);
		cmp({31'h0, irq}, 32'h0);
		$display("test sync done");
	endtask
	task automatic report_and_stop(input logic hung);
		fail_count += int'(hung);
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_drive();
		t_out();
		t_emg();
		t_sync();
		report_and_stop(1'b0);
	end
endmodule
bind pmc_axis pmc_axis_monitor mon (.*);
